//--- common/pwmtl_map.svh
`ifndef PWMTL_MAP_SVH
`define PWMTL_MAP_SVH

// Clock period of core_clk in picoseconds (20 MHz).
`define PWMTL_CLK_PS 50000

// Blanking times in picoseconds.
`define PWMTL_SHORT_BLANK_PS 60000
`define PWMTL_LONG_BLANK_PS 100000

// Least-time counts round up, never below one cycle.
`define PWMTL_SHORT_BLANK_CYC ((`PWMTL_SHORT_BLANK_PS + `PWMTL_CLK_PS - 1) / `PWMTL_CLK_PS)
`define PWMTL_LONG_BLANK_CYC ((`PWMTL_LONG_BLANK_PS + `PWMTL_CLK_PS - 1) / `PWMTL_CLK_PS)

// Overload duration in microseconds and its cycle count at 20 MHz.
`define PWMTL_OVERLOAD_US 30000
`define PWMTL_OVERLOAD_CYC (`PWMTL_OVERLOAD_US * 20)

// Auto-recovery period in microseconds and its cycle count.
`define PWMTL_RECOVERY_US 1000000
`define PWMTL_RECOVERY_CYC (`PWMTL_RECOVERY_US * 20)

// Analog levels in millivolts, as seen at the sense and feedback pins.
`define PWMTL_CURRENT_LIMIT_MV 495
`define PWMTL_SHORT_CIRCUIT_MV 625
`define PWMTL_SKIP_MV 300
`define PWMTL_SKIP_HYS_MV 25
`define PWMTL_SLOPE_PEAK_MV 98

// Feedback divider 5R/R gives a divide-by-six attenuation.
`define PWMTL_FB_DIV 6
// Soft-start ramp divide factor.
`define PWMTL_SS_DIV 6

// Duty positions in percent.
`define PWMTL_SLOPE_START_PCT 40
`define PWMTL_MAX_DUTY_PCT 80

// Consecutive short-circuit trips that cause fault.
`define PWMTL_SC_LIMIT 4

`endif

//--- common/pwmtl_pkg.sv
package pwmtl_pkg;

  // Source that ended the last drive pulse.
  typedef enum logic [2:0]
  {
    PWMTL_END_NONE,
    PWMTL_END_FEEDBACK,
    PWMTL_END_CURRENT_LIMIT,
    PWMTL_END_SHORT,
    PWMTL_END_MAX_DUTY,
    PWMTL_END_SOFT_START
  } pwmtl_end_type;

  // Operating state of the pulse controller.
  typedef enum logic [1:0]
  {
    PWMTL_RUN,
    PWMTL_FAULT
  } pwmtl_state_type;

endpackage

//--- core/pwmtl_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a change counts once stages two and three agree.
module pwmtl_sync
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [2:0] stage_reg; // Shift chain, stage 0 is read only by stage 1.
  logic       out_reg;   // Filtered level.

  // Shift the pin level through the chain.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_reg <= 3'h0;
    end
    else
    begin
      stage_reg <= {stage_reg[1:0], async_in};
    end
  end

  // Accept the new level only when the later stages agree.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_reg <= 1'b0;
    end
    else if (stage_reg[1] == stage_reg[2])
    begin
      out_reg <= stage_reg[2];
    end
  end

  assign sync_out = out_reg;

endmodule

`default_nettype wire

//--- core/pwmtl_slope.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwmtl_map.svh"

// Compensation ramp in millivolts, timed from the phase counter.
module pwmtl_slope
#(
  parameter int PHASE_W = 8
)
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [PHASE_W-1:0] phase,
  input  wire logic [PHASE_W-1:0] period_len,
  output logic      [9:0]         slope_mv
);

  logic [31:0] start_pos;  // Phase at start duty point.
  logic [31:0] span;       // Phases from start to max duty.
  logic [31:0] into_ramp;  // Phases past start.
  logic [9:0]  slope_reg;  // Registered ramp value.

  // Duty positions scale with period, so the slope scales with frequency.
  always_comb
  begin
    start_pos = (32'(period_len) * `PWMTL_SLOPE_START_PCT) / 100;
    span      = (32'(period_len) * (`PWMTL_MAX_DUTY_PCT - `PWMTL_SLOPE_START_PCT)) / 100;
    into_ramp = 32'(phase) - start_pos;
  end

  // Ramp rises from zero at the start point to the peak at max duty.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slope_reg <= 10'h000;
    end
    else if (32'(phase) < start_pos || span == 32'h0)
    begin
      slope_reg <= 10'h000; // Before the start point there is no reduction.
    end
    else if (into_ramp >= span)
    begin
      slope_reg <= 10'(`PWMTL_SLOPE_PEAK_MV);
    end
    else
    begin
      slope_reg <= 10'((into_ramp * `PWMTL_SLOPE_PEAK_MV) / span);
    end
  end

  assign slope_mv = slope_reg;

endmodule

`default_nettype wire

//--- core/pwmtl_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwmtl_map.svh"

// Contract
// - Sense above limit ends the pulse.
// - Overload timer full disables pulses, faults.
// - Overload timer counts up, down, clears only in fault.
// - Short-circuit trip ends pulse, counts trip.
// - Four consecutive trips disable pulses, fault.
// - Sense pulled low, short blanking after rise.
// - Long blanking before limit and feedback compare.
// - Feedback below skip level blanks new pulses.
// - Resume above skip level plus hysteresis.
// - Max duty fraction ends the pulse.
// - Ramp starts at 40 percent, peak 98 mV.
// - Ramp timed to duty positions, frequency scaled.
// - Same ramp lowers current-limit threshold.
// - Feedback divided by six before comparing.
// - Sense above compensated feedback ends pulse.
// - Startup: sense above soft-start/6 ends pulse.
// - Overload fault restarts after recovery period.
module pwmtl_core
  import pwmtl_pkg::*;
#(
  parameter int PHASE_W      = 8,
  parameter int OVERLOAD_CYC = `PWMTL_OVERLOAD_CYC,
  parameter int RECOVERY_CYC = `PWMTL_RECOVERY_CYC
)
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [PHASE_W-1:0] period_len,
  input  wire logic [11:0]        sense_mv,
  input  wire logic [11:0]        feedback_mv,
  input  wire logic [11:0]        soft_start_mv,
  input  wire logic               soft_start_done,
  output logic                    gate_drive_out,
  output logic                    sense_pulldown,
  output logic                    sense_connect,
  output logic                    short_circuit_trip,
  output logic                    skip_active,
  output logic                    fault_active,
  output pwmtl_end_type           end_source
);

  localparam int SHORT_CYC = (`PWMTL_SHORT_BLANK_CYC < 1) ? 1 : `PWMTL_SHORT_BLANK_CYC;
  localparam int LONG_CYC  = (`PWMTL_LONG_BLANK_CYC < 1) ? 1 : `PWMTL_LONG_BLANK_CYC;
  localparam int OVL_W     = $clog2(OVERLOAD_CYC + 1);
  localparam int REC_W     = $clog2(RECOVERY_CYC + 1);

  logic [PHASE_W-1:0] phase_reg;       // Position within the period.
  logic               drive_reg;       // Gate drive latch.
  logic [3:0]         blank_reg;       // Cycles since drive rose, saturating.
  logic [OVL_W-1:0]   overload_reg;    // Integrating overload timer.
  logic [2:0]         sc_count_reg;    // Consecutive short-circuit pulses.
  logic               ss_done_sync;    // Soft-start done flag after the synchroniser.
  logic               skip_reg;        // Skip blanking state.
  pwmtl_state_type    state_reg;       // Run or fault.
  logic [REC_W-1:0]   recover_reg;     // Auto-recovery countdown.
  pwmtl_end_type      end_reg;         // Source that ended last pulse.
  logic               sc_trip_reg;     // Registered trip indication.
  logic [9:0]         slope_mv;        // Compensation ramp.
  logic               period_start;    // First phase of period.
  logic               short_open;      // Short blanking over.
  logic               long_open;       // Long blanking over.
  logic [13:0]        fb_level;        // Attenuated compensated feedback, x6 scale.
  logic               hit_limit;       // Current-limit comparator.
  logic               hit_short;       // Short-circuit comparator.
  logic               hit_feedback;    // Feedback comparator.
  logic               hit_soft;        // Soft-start comparator.
  logic               hit_max_duty;    // Max duty clamp.
  logic               stop_pulse;      // Any termination source.
  pwmtl_end_type      stop_src;        // Winning source.
  logic [31:0]        max_pos;         // Phase of max duty.

  // Returns true when the saturating blank counter has reached a count.
  function automatic logic blank_done(input logic [3:0] cnt, input int lim);
    blank_done = 32'(cnt) >= lim;
  endfunction

  pwmtl_slope #(
    .PHASE_W (PHASE_W)
  ) u_slope (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .phase      (phase_reg),
    .period_len (period_len),
    .slope_mv   (slope_mv)
  );

  // The soft-start done flag comes from a pin comparator, so it is synchronised.
  pwmtl_sync u_done_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (soft_start_done),
    .sync_out (ss_done_sync)
  );

  // Phase counter wraps at the programmed period length.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= '0;
    end
    else if (32'(phase_reg) + 1 >= 32'(period_len))
    begin
      phase_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // Comparators and termination priority.
  always_comb
  begin
    period_start = (phase_reg == '0);
    short_open   = drive_reg && blank_done(blank_reg, SHORT_CYC);
    long_open    = drive_reg && blank_done(blank_reg, LONG_CYC);
    max_pos      = (32'(period_len) * `PWMTL_MAX_DUTY_PCT) / 100;
    // Feedback divided by six; compare sense*6 to avoid division.
    fb_level     = 14'(feedback_mv) - 14'(`PWMTL_FB_DIV) * 14'(slope_mv);
    if (14'(feedback_mv) < 14'(`PWMTL_FB_DIV) * 14'(slope_mv))
    begin
      fb_level = 14'h0000; // Ramp cannot take the level below zero.
    end
    hit_short    = short_open && (sense_mv > 12'(`PWMTL_SHORT_CIRCUIT_MV));
    hit_limit    = long_open && (13'(sense_mv) + 13'(slope_mv)
                   > 13'(`PWMTL_CURRENT_LIMIT_MV));
    hit_feedback = long_open && (15'(`PWMTL_FB_DIV) * 15'(sense_mv) > 15'(fb_level));
    hit_soft     = long_open && !ss_done_sync
                   && (15'(`PWMTL_SS_DIV) * 15'(sense_mv) > 15'(soft_start_mv));
    hit_max_duty = drive_reg && (32'(phase_reg) >= max_pos);
    stop_pulse   = hit_short | hit_limit | hit_feedback | hit_soft | hit_max_duty;
    if (hit_short)
    begin
      stop_src = PWMTL_END_SHORT;
    end
    else if (hit_limit)
    begin
      stop_src = PWMTL_END_CURRENT_LIMIT;
    end
    else if (hit_feedback)
    begin
      stop_src = PWMTL_END_FEEDBACK;
    end
    else if (hit_soft)
    begin
      stop_src = PWMTL_END_SOFT_START;
    end
    else
    begin
      stop_src = PWMTL_END_MAX_DUTY;
    end
  end

  // Drive latch: set at period start, cleared by any source.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_reg <= 1'b0;
    end
    else if (state_reg == PWMTL_FAULT || skip_reg)
    begin
      drive_reg <= 1'b0;
    end
    else if (drive_reg && stop_pulse)
    begin
      drive_reg <= 1'b0;
    end
    else if (period_start)
    begin
      drive_reg <= 1'b1;
    end
  end

  // Saturating count of cycles since the drive rose.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blank_reg <= 4'h0;
    end
    else if (!drive_reg)
    begin
      blank_reg <= 4'h0;
    end
    else if (blank_reg != 4'hf)
    begin
      blank_reg <= blank_reg + 4'h1;
    end
  end

  // Last termination source, reported for observation.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      end_reg     <= PWMTL_END_NONE;
      sc_trip_reg <= 1'b0;
    end
    else
    begin
      sc_trip_reg <= drive_reg && hit_short;
      if (drive_reg && stop_pulse)
      begin
        end_reg <= stop_src;
      end
    end
  end

  // Integrating overload timer stepped once per ended pulse.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overload_reg <= '0;
    end
    else if (state_reg == PWMTL_FAULT)
    begin
      overload_reg <= '0;
    end
    else if (drive_reg && stop_pulse && stop_src == PWMTL_END_CURRENT_LIMIT)
    begin
      // Credit a whole period per limited pulse.
      if (32'(overload_reg) + 32'(period_len) >= OVERLOAD_CYC)
      begin
        overload_reg <= OVL_W'(OVERLOAD_CYC);
      end
      else
      begin
        overload_reg <= overload_reg + OVL_W'(period_len);
      end
    end
    else if (drive_reg && stop_pulse)
    begin
      // Other sources ramp down without clearing.
      if (32'(overload_reg) > 32'(period_len))
      begin
        overload_reg <= overload_reg - OVL_W'(period_len);
      end
      else
      begin
        overload_reg <= '0;
      end
    end
  end

  // Consecutive short-circuit pulse counter.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sc_count_reg <= 3'h0;
    end
    else if (state_reg == PWMTL_FAULT)
    begin
      sc_count_reg <= 3'h0;
    end
    else if (drive_reg && stop_pulse)
    begin
      if (hit_short)
      begin
        sc_count_reg <= sc_count_reg + 3'h1;
      end
      else
      begin
        sc_count_reg <= 3'h0;
      end
    end
  end

  // Skip comparator with hysteresis.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      skip_reg <= 1'b0;
    end
    else if (feedback_mv < 12'(`PWMTL_SKIP_MV))
    begin
      skip_reg <= 1'b1;
    end
    else if (feedback_mv > 12'(`PWMTL_SKIP_MV + `PWMTL_SKIP_HYS_MV))
    begin
      skip_reg <= 1'b0;
    end
  end

  // Fault state with auto-recovery timer.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= PWMTL_RUN;
      recover_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        PWMTL_RUN:
        begin
          if (32'(overload_reg) >= OVERLOAD_CYC
              || 32'(sc_count_reg) >= `PWMTL_SC_LIMIT)
          begin
            state_reg   <= PWMTL_FAULT;
            recover_reg <= REC_W'(RECOVERY_CYC);
          end
        end
        PWMTL_FAULT:
        begin
          if (recover_reg <= REC_W'(1))
          begin
            state_reg <= PWMTL_RUN;
          end
          else
          begin
            recover_reg <= recover_reg - 1'b1;
          end
        end
      endcase
    end
  end

  assign gate_drive_out     = drive_reg;
  assign sense_pulldown     = !short_open;
  assign sense_connect      = long_open;
  assign short_circuit_trip = sc_trip_reg;
  assign skip_active        = skip_reg;
  assign fault_active       = (state_reg == PWMTL_FAULT);
  assign end_source         = end_reg;

endmodule

`default_nettype wire

//--- test/pwmtl_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on blanking, pulse ending, skip and fault behaviour.
module pwmtl_core_monitor
  import pwmtl_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst_n,
  input wire logic [7:0]    period_len,
  input wire logic [11:0]   sense_mv,
  input wire logic [11:0]   feedback_mv,
  input wire logic [11:0]   soft_start_mv,
  input wire logic          soft_start_done,
  input wire logic          gate_drive_out,
  input wire logic          sense_pulldown,
  input wire logic          sense_connect,
  input wire logic          short_circuit_trip,
  input wire logic          skip_active,
  input wire logic          fault_active,
  input wire pwmtl_end_type end_source
);
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic [8:0] high_cnt_reg; // Cycles the drive has been high in this pulse.

  // Counts the length of the running pulse, cleared while the drive is low.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      high_cnt_reg <= 9'h000;
    else if (gate_drive_out)
      high_cnt_reg <= high_cnt_reg + 9'h001;
    else
      high_cnt_reg <= 9'h000;
  end

  pull_low_a: assert property (!gate_drive_out |-> sense_pulldown)
    else $error("sense not held low while drive is low");
  blank_window_a: assert property ($rose(gate_drive_out) |->
    (sense_pulldown && !sense_connect) [*2] ##1
    (!gate_drive_out || (!sense_pulldown && sense_connect)))
    else $error("blanking window has the wrong length");
  connect_drive_a: assert property (sense_connect |-> gate_drive_out && !sense_pulldown)
    else $error("sense path closed outside a pulse");
  limit_end_a: assert property (
    gate_drive_out && sense_connect && sense_mv > 12'h1ef |=> !gate_drive_out)
    else $error("pulse survived sense above the limit");
  short_end_a: assert property (
    gate_drive_out && !sense_pulldown && sense_mv > 12'h271
    |=> !gate_drive_out ##[0:1] short_circuit_trip)
    else $error("short circuit did not end the pulse with a trip");
  trip_pulse_a: assert property (short_circuit_trip |=> !short_circuit_trip)
    else $error("trip lasted more than one cycle");
  skip_enter_a: assert property (feedback_mv < 12'h12c [*3] |-> skip_active)
    else $error("low feedback did not start skipping");
  skip_hold_a: assert property (skip_active && feedback_mv <= 12'h145 |=> skip_active)
    else $error("skip left inside the hysteresis band");
  skip_quiet_a: assert property (skip_active [*2] |-> !gate_drive_out)
    else $error("drive pulse while skipping");
  fault_quiet_a: assert property (fault_active [*2] |-> !gate_drive_out)
    else $error("drive pulse in fault mode");
  duty_clamp_a: assert property (
    int'(high_cnt_reg) <= int'(period_len) * 4 / 5 + 2)
    else $error("pulse longer than the duty clamp");

  short_seen_c: cover property ($rose(short_circuit_trip));
  fault_seen_c: cover property ($rose(fault_active));
  skip_seen_c: cover property ($rose(skip_active));
endmodule

`default_nettype wire

//--- test/pwmtl_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

// Power switch and sense resistor: the sense pin steps and ramps while on.
module pwmtl_switch_model
(
  input  wire logic        core_clk,
  input  wire logic        gate_drive_out,
  input  wire logic        sense_pulldown,
  input  wire logic [11:0] base_mv,
  input  wire logic [11:0] step_mv,
  output logic      [11:0] sense_mv
);
  logic [11:0] ramp_reg; // Current image built up since the switch turned on.

  // The ramp restarts from zero whenever the switch is off.
  always_ff @(posedge core_clk)
  begin
    if (!gate_drive_out)
      ramp_reg <= 12'h000;
    else
      ramp_reg <= ramp_reg + step_mv;
  end

  // The pin reads zero while the device's pulldown switch holds it.
  assign sense_mv = sense_pulldown ? 12'h000 : base_mv + ramp_reg;
endmodule

`default_nettype wire

//--- test/pwmtl_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end

// Drives the pulse controller through every ending source, skip and faults.
module pwmtl_core_bench
  import pwmtl_pkg::*;
;
  localparam int OVL = 2000; // Shortened overload span in cycles.
  localparam int REC = 100;  // Shortened recovery span in cycles.
  logic          core_clk, rst_n;
  logic [7:0]    period_len;
  logic [11:0]   feedback_mv, soft_start_mv, base_mv, step_mv, sense_mv;
  logic          soft_start_done, gate_drive_out, sense_pulldown, sense_connect;
  logic          short_circuit_trip, skip_active, fault_active;
  pwmtl_end_type end_source;
  int            miscompares, cmp_count, trips, w, k;

  pwmtl_core #(.PHASE_W(8), .OVERLOAD_CYC(OVL), .RECOVERY_CYC(REC)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .period_len(period_len), .sense_mv(sense_mv),
    .feedback_mv(feedback_mv), .soft_start_mv(soft_start_mv),
    .soft_start_done(soft_start_done), .gate_drive_out(gate_drive_out),
    .sense_pulldown(sense_pulldown), .sense_connect(sense_connect),
    .short_circuit_trip(short_circuit_trip), .skip_active(skip_active),
    .fault_active(fault_active), .end_source(end_source));
  pwmtl_switch_model sw (.core_clk(core_clk), .gate_drive_out(gate_drive_out),
    .sense_pulldown(sense_pulldown), .base_mv(base_mv), .step_mv(step_mv),
    .sense_mv(sense_mv));

  // Free-running 50 ns clock.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Counts short-circuit trip pulses.
  always @(posedge core_clk)
    if (short_circuit_trip === 1'b1)
      trips++;

  // Moves to 5 ns after the n-th next rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  // Resets the block for two cycles with fresh operating levels.
  task automatic setup(input logic [7:0] per, input logic [11:0] fb, bs, st);
    rst_n = 1'b0;
    period_len = per;
    feedback_mv = fb;
    base_mv = bs;
    step_mv = st;
    soft_start_mv = 12'hfff;
    soft_start_done = 1'b1;
    trips = 0;
    cyc(2);
    rst_n = 1'b1;
  endtask

  // Waits for the next drive pulse and returns its width in cycles.
  task automatic pulse(output int wd);
    int n;
    n = 0;
    while (gate_drive_out !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    wd = 0;
    while (gate_drive_out === 1'b1 && wd < 300)
    begin
      cyc(1);
      wd++;
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("Compared %0d, mismatched %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // No sense signal: only the duty clamp can end the pulse.
  task automatic t_max;
    setup(8'hc8, 12'hfff, 12'h000, 12'h000);
    pulse(w);
    `CHK(w inside {[160:161]}, 1'b1);
    `CHK(end_source, PWMTL_END_MAX_DUTY);
  endtask

  // Flat 450 mV sense: the ramp lowers the limit to it, at two frequencies.
  task automatic t_slope;
    setup(8'hc8, 12'hfff, 12'h1c2, 12'h000);
    pulse(w);
    `CHK(w inside {[116:123]}, 1'b1);
    `CHK(end_source, PWMTL_END_CURRENT_LIMIT);
    setup(8'h64, 12'hfff, 12'h1c2, 12'h000);
    pulse(w);
    `CHK(w inside {[57:64]}, 1'b1);
  endtask

  // Rising sense meets the divided feedback, then the soft-start level.
  task automatic t_feed;
    setup(8'hc8, 12'h708, 12'h000, 12'h004);
    pulse(w);
    `CHK(end_source, PWMTL_END_FEEDBACK);
    `CHK(w inside {[70:82]}, 1'b1);
    soft_start_done = 1'b0;
    soft_start_mv = 12'h258;
    pulse(w);
    `CHK(end_source, PWMTL_END_SOFT_START);
    `CHK(w inside {[22:32]}, 1'b1);
  endtask

  // Limit endings credit the timer, feedback endings debit it.
  task automatic t_ovl;
    setup(8'hc8, 12'hfff, 12'h1f4, 12'h000);
    repeat (5) pulse(w);
    base_mv = 12'h000;
    step_mv = 12'h004;
    feedback_mv = 12'h708;
    repeat (2) pulse(w);
    `CHK(end_source, PWMTL_END_FEEDBACK);
    `CHK(fault_active, 1'b0);
    base_mv = 12'h1f4;
    step_mv = 12'h000;
    feedback_mv = 12'hfff;
    k = 0;
    do
    begin
      pulse(w);
      cyc(3);
      k++;
    end
    while (fault_active !== 1'b1 && k < 12);
    `CHK(k, 7);
    k = 0;
    while (fault_active === 1'b1 && k < 1000)
    begin
      cyc(1);
      k++;
    end
    `CHK(k inside {[REC - 8:REC + 2]}, 1'b1);
  endtask

  // Short circuits with one clean pulse breaking the run of trips.
  task automatic t_short;
    setup(8'hc8, 12'hfff, 12'h2bc, 12'h000);
    for (k = 0; k < 8; k++)
    begin
      base_mv = (k == 3) ? 12'h000 : 12'h2bc;
      pulse(w);
      cyc(2);
      `CHK(fault_active, k == 7);
    end
    `CHK(end_source, PWMTL_END_SHORT);
    `CHK(trips, 7);
  endtask

  // Feedback below the skip level, inside the band, then above it.
  task automatic t_skip;
    setup(8'hc8, 12'hfff, 12'h000, 12'h000);
    pulse(w);
    feedback_mv = 12'h122;
    cyc(5);
    `CHK(skip_active, 1'b1);
    feedback_mv = 12'h140;
    k = 0;
    repeat (400)
    begin
      cyc(1);
      if (gate_drive_out !== 1'b0)
        k++;
    end
    `CHK(k, 0);
    feedback_mv = 12'h14a;
    pulse(w);
    `CHK(skip_active, 1'b0);
    `CHK(w > 0, 1'b1);
  endtask

  // Main sequence.
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    t_max();
    t_slope();
    t_feed();
    t_ovl();
    t_short();
    t_skip();
    test_done();
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #2000000;
    miscompares++;
    test_done();
  end
endmodule

bind pwmtl_core pwmtl_core_monitor mon (.core_clk(core_clk), .rst_n(rst_n),
  .period_len(period_len), .sense_mv(sense_mv), .feedback_mv(feedback_mv),
  .soft_start_mv(soft_start_mv), .soft_start_done(soft_start_done),
  .gate_drive_out(gate_drive_out), .sense_pulldown(sense_pulldown),
  .sense_connect(sense_connect), .short_circuit_trip(short_circuit_trip),
  .skip_active(skip_active), .fault_active(fault_active), .end_source(end_source));

`default_nettype wire
